/* plc_change_det.sv */
// Module: level change detector with sticky, clear-on-read status
module plc_change_det #(
	parameter int W = 32
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] lvl_i,
	input wire logic clr_i,
	output logic [W-1:0] evt_o,
	output logic [W-1:0] status_o
);
	logic [W-1:0] prev_r;
	logic [W-1:0] status_nxt;

	if (W < 1) begin : g_bad_w
		$error("plc_change_det: W must be at least 1");
	end

	// Either edge counts as a change
	assign evt_o = lvl_i ^ prev_r;

	// A fresh change beats the read clear so no event is lost
	assign status_nxt = (clr_i ? '0 : status_o) | evt_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_r <= lvl_i;
			status_o <= '0;
		end else if (ce_i) begin
			prev_r <= lvl_i;
			status_o <= status_nxt;
		end
	end
endmodule

/* plc_filt_if.sv */
// Interface: raw pins, filter selects and cleaned levels between top and filter
interface plc_filt_if #(parameter int W = 32);
	logic [W-1:0] raw;
	logic [W-1:0] en;
	logic [W-1:0] lvl;
	modport host (output raw, output en, input lvl);
	modport filt (input raw, input en, output lvl);
endinterface

/* plc_glitch_filter.sv */
// Module: per-line input glitch filter
module plc_glitch_filter #(
	parameter int W = 32
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	plc_filt_if.filt f
);
	wire [W-1:0] lvl_w;

	if (W < 1 || W > 32) begin : g_bad_w
		$error("plc_glitch_filter: W must be 1 to 32");
	end

	// One sampler per line; a filtered line needs two equal samples
	for (genvar i = 0; i < W; i++) begin : g_line
		logic samp_r;
		logic lvl_r;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				samp_r <= f.raw[i];
				lvl_r <= f.raw[i]; // Level at reset mirrors the pin
			end else if (ce_i) begin
				samp_r <= f.raw[i];
				if (!f.en[i] || f.raw[i] == samp_r) begin
					lvl_r <= f.raw[i];
				end
			end
		end
		assign lvl_w[i] = lvl_r;
	end

	assign f.lvl = lvl_w;
endmodule

/* plc_pin_model.sv */
// Partner model: package pins and the on-chip peripheral behind each line
module plc_pin_model import plc_pkg::*; (
	input wire logic [REG_W-1:0] ctl_out_i,
	input wire logic [REG_W-1:0] ctl_oe_i,
	input wire logic [REG_W-1:0] ext_lvl_i,
	input wire logic [REG_W-1:0] per_lvl_i,
	input wire logic [REG_W-1:0] per_en_i,
	output logic [REG_W-1:0] pin_lvl_o,
	output logic [REG_W-1:0] per_out_o,
	output logic [REG_W-1:0] per_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////////
	// Peripheral side: level and enable the on-chip function would drive
	assign per_out_o = per_lvl_i;
	assign per_oe_o = per_en_i;
	// Driven lines show their driver, undriven ones the board level
	assign pin_lvl_o = (ctl_out_i & ctl_oe_i) | (ext_lvl_i & ~ctl_oe_i);
endmodule

/* plc_pkg.sv */
// Package: register map, reset values and line masks of the line controller
package plc_pkg;
	localparam int REG_W = 32;
	localparam int ADR_W = 7;
	localparam logic [ADR_W-1:0] OFF_OWN_TAKE = 7'h00;
	localparam logic [ADR_W-1:0] OFF_OWN_REL = 7'h04;
	localparam logic [ADR_W-1:0] OFF_OWN_STAT = 7'h08;
	localparam logic [ADR_W-1:0] OFF_DRV_SET = 7'h10;
	localparam logic [ADR_W-1:0] OFF_DRV_CLR = 7'h14;
	localparam logic [ADR_W-1:0] OFF_DRV_STAT = 7'h18;
	localparam logic [ADR_W-1:0] OFF_FLT_SET = 7'h20;
	localparam logic [ADR_W-1:0] OFF_FLT_CLR = 7'h24;
	localparam logic [ADR_W-1:0] OFF_FLT_STAT = 7'h28;
	localparam logic [ADR_W-1:0] OFF_OUT_SET = 7'h30;
	localparam logic [ADR_W-1:0] OFF_OUT_CLR = 7'h34;
	localparam logic [ADR_W-1:0] OFF_OUT_STAT = 7'h38;
	localparam logic [ADR_W-1:0] OFF_PIN_STAT = 7'h3C;
	localparam logic [ADR_W-1:0] OFF_IRQ_EN = 7'h40;
	localparam logic [ADR_W-1:0] OFF_IRQ_DIS = 7'h44;
	localparam logic [ADR_W-1:0] OFF_IRQ_MASK = 7'h48;
	localparam logic [ADR_W-1:0] OFF_CHG_STAT = 7'h4C;
	localparam logic [REG_W-1:0] OWNER_RST = 32'h01FFFFFF;
	localparam logic [REG_W-1:0] CFG_RST = 32'h00000000;
	localparam logic [REG_W-1:0] LINE_MASK_DEF = 32'hFFFFFFFF;
	localparam logic [REG_W-1:0] DED_MASK_DEF = 32'h018F0000;
endpackage

/* plc_top.sv */
// Top: parallel line controller with classic Wishbone register slave
//
// The Wishbone register port was left to the implementer.
module plc_top import plc_pkg::*; #(
	parameter logic [REG_W-1:0] LINE_MASK = LINE_MASK_DEF,
	parameter logic [REG_W-1:0] DED_MASK = DED_MASK_DEF
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [REG_W-1:0] wb_dat_i,
	output logic [REG_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [REG_W-1:0] pin_i,
	output logic [REG_W-1:0] pin_o,
	output logic [REG_W-1:0] pin_oe_o,
	input wire logic [REG_W-1:0] per_out_i,
	input wire logic [REG_W-1:0] per_oe_i,
	output logic [REG_W-1:0] per_in_o,
	output logic irq_o
);
	////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	if ((DED_MASK & ~LINE_MASK) != '0) begin : g_bad_ded
		$error("plc_top: dedicated lines must be implemented lines");
	end

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic ack_r;
	logic acc;
	logic wr;
	logic rd_chg;
	logic [REG_W-1:0] lane_mask;
	logic [REG_W-1:0] wmask;
	logic [REG_W-1:0] rdata;
	logic [REG_W-1:0] owner_r;
	logic [REG_W-1:0] drv_en_r;
	logic [REG_W-1:0] flt_en_r;
	logic [REG_W-1:0] out_lvl_r;
	logic [REG_W-1:0] irq_mask_r;
	logic [REG_W-1:0] chg_evt;
	logic [REG_W-1:0] chg_stat;
	logic [REG_W-1:0] lvl;

	plc_filt_if #(.W(REG_W)) fif ();

	////////////////////////////////////////////////////////////////////////
	// Bus slave

	// A request is taken on its first cycle; ack follows one cycle later
	assign acc = wb_cyc_i & wb_stb_i & ~ack_r & ce_i;
	assign wr = acc & wb_we_i;
	assign rd_chg = acc & ~wb_we_i & (wb_adr_i == OFF_CHG_STAT);

	// Byte lanes gate writes; bits with no line never change
	assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wmask = wb_dat_i & lane_mask & LINE_MASK;

	// Ack drops the cycle after it rose, even with stb still high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else if (ce_i) begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
		end
	end
	assign wb_ack_o = ack_r;

	// Read mux; write-only and unmapped words read zero
	always_comb begin
		rdata = '0;
		unique case (wb_adr_i)
			OFF_OWN_STAT: rdata = owner_r;
			OFF_DRV_STAT: rdata = drv_en_r;
			OFF_FLT_STAT: rdata = flt_en_r;
			OFF_OUT_STAT: rdata = out_lvl_r;
			OFF_PIN_STAT: rdata = lvl;
			OFF_IRQ_MASK: rdata = irq_mask_r;
			OFF_CHG_STAT: rdata = chg_stat;
			default: rdata = '0;
		endcase
	end

	// Read data is captured with the request so it stands with ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (acc) begin
			wb_dat_o <= wb_we_i ? '0 : (rdata & LINE_MASK);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ownership

	// Dedicated lines have no peripheral, so they stay owned
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			owner_r <= (OWNER_RST | DED_MASK) & LINE_MASK;
		end else if (wr && wb_adr_i == OFF_OWN_TAKE) begin
			owner_r <= owner_r | (wmask & ~DED_MASK);
		end else if (wr && wb_adr_i == OFF_OWN_REL) begin
			owner_r <= owner_r & ~(wmask & ~DED_MASK);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Direction, filter, output level and mask registers

	// Direction is stored even while a peripheral owns the line
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drv_en_r <= CFG_RST;
		end else if (wr && wb_adr_i == OFF_DRV_SET) begin
			drv_en_r <= drv_en_r | wmask;
		end else if (wr && wb_adr_i == OFF_DRV_CLR) begin
			drv_en_r <= drv_en_r & ~wmask;
		end
	end

	// Filter select acts on every line whatever its owner
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flt_en_r <= CFG_RST;
		end else if (wr && wb_adr_i == OFF_FLT_SET) begin
			flt_en_r <= flt_en_r | wmask;
		end else if (wr && wb_adr_i == OFF_FLT_CLR) begin
			flt_en_r <= flt_en_r & ~wmask;
		end
	end

	// Output data is latched always, put on pin_o whenever the line is owned
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_lvl_r <= CFG_RST;
		end else if (wr && wb_adr_i == OFF_OUT_SET) begin
			out_lvl_r <= out_lvl_r | wmask;
		end else if (wr && wb_adr_i == OFF_OUT_CLR) begin
			out_lvl_r <= out_lvl_r & ~wmask;
		end
	end

	// Mask bits only gate the interrupt; detection keeps running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_r <= CFG_RST;
		end else if (wr && wb_adr_i == OFF_IRQ_EN) begin
			irq_mask_r <= irq_mask_r | wmask;
		end else if (wr && wb_adr_i == OFF_IRQ_DIS) begin
			irq_mask_r <= irq_mask_r & ~wmask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input path: filter, level status and change detection

	assign fif.raw = pin_i;
	assign fif.en = flt_en_r;
	assign lvl = fif.lvl & LINE_MASK;

	plc_glitch_filter #(.W(REG_W)) u_filter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.f(fif.filt)
	);

	plc_change_det #(.W(REG_W)) u_change (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.lvl_i(lvl),
		.clr_i(rd_chg),
		.evt_o(chg_evt),
		.status_o(chg_stat)
	);

	// Any unmasked pending change raises the single interrupt
	assign irq_o = |(chg_stat & irq_mask_r);

	////////////////////////////////////////////////////////////////////////
	// Pin and peripheral muxing

	// Owned lines use the stored direction; others follow the peripheral
	assign pin_oe_o = LINE_MASK &
		((owner_r & drv_en_r) | (~owner_r & per_oe_i));
	assign pin_o = LINE_MASK &
		((owner_r & out_lvl_r) | (~owner_r & per_out_i));

	// Peripheral sees the filtered pin only when it owns the line
	assign per_in_o = ~owner_r & lvl;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	chk_owner_reset: assert property (@(posedge clk_i)
		$fell(rst_i) |-> owner_r == ((OWNER_RST | DED_MASK) & LINE_MASK)
			&& drv_en_r == '0 && chg_stat == '0)
		else $error("owner or config wrong after reset");

	chk_ded_owned: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(owner_r & DED_MASK) == DED_MASK)
		else $error("dedicated line lost controller ownership");

	chk_take_sets: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_OWN_TAKE |=>
			((owner_r & $past(wmask)) == $past(wmask))
			&& ((owner_r & ~$past(wmask))
				== ($past(owner_r) & ~$past(wmask))))
		else $error("ownership take did not apply");

	chk_release_clr: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_OWN_REL |=>
			(owner_r & $past(wmask) & ~DED_MASK) == '0)
		else $error("ownership release did not apply");

	chk_per_in_zero: assert property (@(posedge clk_i)
		disable iff (rst_i)
		##1 (per_in_o & owner_r) == '0)
		else $error("peripheral input not held low on owned line");

	chk_drive_mux: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_DRV_SET && (wmask & owner_r) != '0 |=>
			(pin_oe_o & $past(wmask) & $past(owner_r))
				== ($past(wmask) & $past(owner_r)))
		else $error("owned line not driven after enable");

	chk_change_sets: assert property (@(posedge clk_i)
		disable iff (rst_i)
		ce_i && chg_evt != '0 |=>
			(chg_stat & $past(chg_evt)) == $past(chg_evt))
		else $error("level change not recorded");

	chk_read_clears: assert property (@(posedge clk_i)
		disable iff (rst_i)
		rd_chg && chg_evt == '0 |=> chg_stat == '0)
		else $error("status read did not clear");

	chk_irq_follows: assert property (@(posedge clk_i)
		disable iff (rst_i)
		ce_i && (chg_evt & irq_mask_r) != '0 && !(wr && wb_adr_i ==
			OFF_IRQ_DIS) |=> irq_o)
		else $error("interrupt missing after masked-in change");

	chk_ack_once: assert property (@(posedge clk_i)
		disable iff (rst_i)
		ce_i && wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	chk_glitch_held: assert property (@(posedge clk_i)
		disable iff (rst_i)
		ce_i && $past(ce_i) && $stable(lvl)
			&& (flt_en_r & (pin_i ^ lvl)) != '0
			&& $past(pin_i) == lvl && flt_en_r == $past(flt_en_r)
			|=> ((lvl ^ $past(lvl)) & $past(flt_en_r)
				& ($past(pin_i) ^ $past(lvl))) == '0)
		else $error("single-cycle glitch passed the filter");

	// Set and clear writes reach every written line
	chk_drive_set: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_DRV_SET |=>
			(drv_en_r & $past(wmask)) == $past(wmask))
		else $error("drive enable set did not apply");

	chk_drive_clear: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_DRV_CLR |=>
			(drv_en_r & $past(wmask)) == '0)
		else $error("drive enable clear did not apply");

	chk_filter_set: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_FLT_SET |=>
			(flt_en_r & $past(wmask)) == $past(wmask))
		else $error("filter set did not apply");

	chk_filter_clear: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_FLT_CLR |=>
			(flt_en_r & $past(wmask)) == '0)
		else $error("filter clear did not apply");

	chk_level_set: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_OUT_SET |=>
			(out_lvl_r & $past(wmask)) == $past(wmask))
		else $error("output level set did not apply");

	chk_level_clear: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_OUT_CLR |=>
			(out_lvl_r & $past(wmask)) == '0)
		else $error("output level clear did not apply");

	chk_mask_set: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_IRQ_EN |=>
			(irq_mask_r & $past(wmask)) == $past(wmask))
		else $error("interrupt enable did not apply");

	chk_mask_clear: assert property (@(posedge clk_i)
		disable iff (rst_i)
		wr && wb_adr_i == OFF_IRQ_DIS |=>
			(irq_mask_r & $past(wmask)) == '0)
		else $error("interrupt disable did not apply");

	// Bus answers next cycle; read data is the level seen at the take
	chk_ack_answer: assert property (@(posedge clk_i)
		disable iff (rst_i)
		ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");

	chk_pin_read: assert property (@(posedge clk_i)
		disable iff (rst_i)
		acc && !wb_we_i && wb_adr_i == OFF_PIN_STAT |=>
			wb_dat_o == $past(lvl))
		else $error("pin level read does not match pins");

	// Absent lines never hold state, so they can never read back
	chk_absent_zero: assert property (@(posedge clk_i)
		disable iff (rst_i)
		((owner_r | drv_en_r | flt_en_r | out_lvl_r | irq_mask_r
			| chg_stat | wb_dat_o) & ~LINE_MASK) == '0)
		else $error("state held on a line that is not present");

	// A low clock enable must freeze the owner, drive, output and mask registers, the change status, the level and ack
	chk_ce_freeze: assert property (@(posedge clk_i)
		disable iff (rst_i)
		!ce_i |=> $stable(owner_r) && $stable(drv_en_r)
			&& $stable(out_lvl_r) && $stable(irq_mask_r)
			&& $stable(chg_stat) && $stable(lvl)
			&& $stable(wb_ack_o))
		else $error("state moved while clock enable was low");

	cov_take: cover property (@(posedge clk_i) disable iff (rst_i)
		wr && wb_adr_i == OFF_OWN_TAKE && wmask != '0);
	cov_release: cover property (@(posedge clk_i) disable iff (rst_i)
		wr && wb_adr_i == OFF_OWN_REL && (wmask & ~DED_MASK) != '0);
	cov_irq_rise: cover property (@(posedge clk_i) disable iff (rst_i)
		!irq_o ##1 irq_o);
	cov_read_race: cover property (@(posedge clk_i) disable iff (rst_i)
		rd_chg && chg_evt != '0);
endmodule

/* testbench.sv */
// Testbench: register, ownership, pin, change and filter checks
module testbench import plc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	// Line 31 left out so unimplemented bits are exercised
	localparam logic [REG_W-1:0] LM = 32'h7FFFFFFF;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [ADR_W-1:0] adr = 7'h00;
	logic [3:0] sel = 4'h0;
	logic [REG_W-1:0] wdat = 32'h00000000;
	logic [REG_W-1:0] ext_lvl = 32'h0F0F00F0;
	logic [REG_W-1:0] per_lvl = 32'h00000000;
	logic [REG_W-1:0] per_en = 32'h00000000;
	logic [REG_W-1:0] rdat, pin_o, pin_oe_o, per_in_o, pin_i, p_out, p_oe, rd;
	logic ack, irq_o;
	int err_total = 0;
	int compares = 0;
	////////////////////////////////////////////////////////////////////////
	always #25 clk_i = ~clk_i;
	plc_top #(.LINE_MASK(LM), .DED_MASK(DED_MASK_DEF)) u_dut (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .per_out_i(p_out), .per_oe_i(p_oe),
		.per_in_o(per_in_o), .irq_o(irq_o));
	plc_pin_model u_pins (.ctl_out_i(pin_o), .ctl_oe_i(pin_oe_o),
		.ext_lvl_i(ext_lvl), .per_lvl_i(per_lvl), .per_en_i(per_en),
		.pin_lvl_o(pin_i), .per_out_o(p_out), .per_oe_o(p_oe));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [REG_W-1:0] exp,
		input logic [REG_W-1:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Classic cycle: hold request until ack is seen, then release
	task automatic xfer(input logic w, input logic [ADR_W-1:0] a,
		input logic [REG_W-1:0] d);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		if (n >= 20) begin
			err_total++;
			$display("mismatch bus ack expected 1 seen 0");
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd_chk(input logic [ADR_W-1:0] a, input string what,
		input logic [REG_W-1:0] exp);
		xfer(1'b0, a, 32'h00000000);
		check(what, exp, rd);
	endtask
	// Pin stimulus lands off the sampling edge by non-blocking assignment
	task automatic flip(input logic [REG_W-1:0] m);
		@(posedge clk_i);
		ext_lvl <= ext_lvl ^ m;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [ADR_W-1:0] z[5] = '{OFF_DRV_STAT, OFF_FLT_STAT, OFF_OUT_STAT,
			OFF_IRQ_MASK, OFF_CHG_STAT};
		rd_chk(OFF_OWN_STAT, "owner_status", 32'h01FFFFFF);
		for (int i = 0; i < 5; i++) begin
			rd_chk(z[i], "zero reset reg", 32'h00000000);
		end
		rd_chk(OFF_PIN_STAT, "pin_level_status", ext_lvl & LM);
		check("pin_oe_o", 32'h00000000, pin_oe_o);
		rd_chk(7'h50, "unmapped", 32'h00000000);
		rd_chk(OFF_OWN_TAKE, "write only", 32'h00000000);
	endtask
	task automatic t_owner();
		xfer(1'b1, OFF_OWN_REL, 32'hFFFFFFFF);
		rd_chk(OFF_OWN_STAT, "released", DED_MASK_DEF);
		xfer(1'b1, OFF_OWN_TAKE, 32'h0000FFFF);
		xfer(1'b1, OFF_OWN_TAKE, 32'h00000000);
		rd_chk(OFF_OWN_STAT, "taken", DED_MASK_DEF | 32'hFFFF);
		check("per_in_o", ext_lvl & LM & ~(DED_MASK_DEF | 32'hFFFF),
			per_in_o & LM);
		xfer(1'b1, OFF_OWN_TAKE, 32'hFFFFFFFF);
		check("per_in_o owned", 32'h00000000, per_in_o & LM);
	endtask
	// Line 1 driven by the controller, line 8 handed to its peripheral
	task automatic t_drive();
		xfer(1'b1, OFF_DRV_SET, 32'hFFFFFFFF);
		rd_chk(OFF_DRV_STAT, "drive all", LM);
		xfer(1'b1, OFF_DRV_CLR, 32'hFFFFFEFD);
		xfer(1'b1, OFF_OUT_SET, 32'h00000103);
		xfer(1'b1, OFF_OUT_CLR, 32'h00000001);
		rd_chk(OFF_OUT_STAT, "out_level", 32'h00000102);
		xfer(1'b1, OFF_OWN_REL, 32'h00000100);
		per_en <= 32'h00000100;
		rd_chk(OFF_DRV_STAT, "drive kept", 32'h00000102);
		check("pin_oe_o", 32'h00000102, pin_oe_o & 32'h103);
		check("pin_o", 32'h00000002, pin_o & 32'h102);
		xfer(1'b0, OFF_PIN_STAT, 32'h00000000);
		check("pin_level_status", 32'h00000002, rd & 32'h102);
		per_en <= 32'h00000000;
		xfer(1'b1, OFF_DRV_CLR, 32'hFFFFFFFF);
		xfer(1'b1, OFF_OWN_TAKE, 32'hFFFFFFFF);
	endtask
	task automatic t_change();
		repeat (4) @(posedge clk_i);
		xfer(1'b0, OFF_CHG_STAT, 32'h00000000);
		xfer(1'b1, OFF_IRQ_EN, 32'h00000030);
		xfer(1'b1, OFF_IRQ_DIS, 32'h00000010);
		rd_chk(OFF_IRQ_MASK, "change_irq_mask", 32'h00000020);
		flip(32'h00000010);
		repeat (4) @(posedge clk_i);
		check("irq masked", 32'h0, {31'h0, irq_o});
		rd_chk(OFF_CHG_STAT, "masked change", 32'h00000010);
		rd_chk(OFF_CHG_STAT, "cleared", 32'h00000000);
		flip(32'h00000020);
		repeat (4) @(posedge clk_i);
		check("irq raised", 32'h1, {31'h0, irq_o});
		rd_chk(OFF_CHG_STAT, "change", 32'h00000020);
		check("irq after read", 32'h0, {31'h0, irq_o});
	endtask
	// One-cycle pulse on lines 2 and 3; only line 3 is filtered
	task automatic t_filter();
		xfer(1'b1, OFF_FLT_SET, 32'h0000000C);
		xfer(1'b1, OFF_FLT_CLR, 32'h00000004);
		rd_chk(OFF_FLT_STAT, "glitch_filter", 32'h00000008);
		flip(32'h0000000C);
		flip(32'h0000000C);
		repeat (4) @(posedge clk_i);
		rd_chk(OFF_CHG_STAT, "short pulse", 32'h00000004);
		flip(32'h00000008);
		repeat (4) @(posedge clk_i);
		rd_chk(OFF_CHG_STAT, "held level", 32'h00000008);
	endtask
	// Enable low freezes the input path; a second reset restores the reset values
	task automatic t_hold();
		xfer(1'b1, OFF_IRQ_EN, 32'h00000001);
		@(posedge clk_i);
		ce <= 1'b0;
		flip(32'h00000001);
		repeat (4) @(posedge clk_i);
		check("irq frozen", 32'h0, {31'h0, irq_o});
		ce <= 1'b1;
		repeat (4) @(posedge clk_i);
		check("irq enabled", 32'h1, {31'h0, irq_o});
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(OFF_CHG_STAT, "reset change", 32'h00000000);
		rd_chk(OFF_IRQ_MASK, "reset mask", 32'h00000000);
		rd_chk(OFF_OWN_STAT, "reset owner", 32'h01FFFFFF);
		check("irq after reset", 32'h0, {31'h0, irq_o});
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_owner();
		t_drive();
		t_change();
		t_filter();
		t_hold();
		finish_test();
	end
	// Whole run needs under two hundred cycles; this cuts a hang short
	initial begin
		repeat (5000) @(posedge clk_i);
		err_total++;
		finish_test();
	end
endmodule
